// File: design/converter_control_params.svh
// Constants for the converter control register bank: offsets, field
// positions, reset values, voltage mapping and ramp timing.
// Assumes inclusion by bare name from design files only.
`ifndef CONVERTER_CONTROL_PARAMS_SVH
`define CONVERTER_CONTROL_PARAMS_SVH

// ==================================================================
// Register offsets
`define CCR_ADDR_SUPPLY_ENABLE 8'h03
`define CCR_ADDR_MODE_PHASE 8'h04
`define CCR_ADDR_VOLT_CHANGE 8'h05
`define CCR_ADDR_CORE_CODE 8'h06
`define CCR_ADDR_RAMP_RATE 8'h07

// ==================================================================
// Reset values
`define CCR_SUPPLY_ENABLE_RST 8'hff
`define CCR_MODE_PHASE_RST 8'hb1
`define CCR_VOLT_CHANGE_RST 8'h40
`define CCR_RAMP_RATE_RST 3'h6
`define CCR_CORE_RST_PIN_LOW 5'h14
`define CCR_CORE_RST_PIN_HIGH 5'h1e
`define CCR_READ_NONE 8'h00

// ==================================================================
// Field positions
`define CCR_SE_FIRST_CONV 5
`define CCR_SE_SECOND_CONV 4
`define CCR_SE_CORE_CONV 3
`define CCR_SE_SECOND_LIN 2
`define CCR_SE_FIRST_LIN 1
`define CCR_MP_SECOND_PHASE 6
`define CCR_MP_CORE_PHASE 4
`define CCR_MP_LOW_RIPPLE 3
`define CCR_VC_START 7
`define CCR_VC_CORE_ADJ 6
`define CCR_CORE_MSB 4
`define CCR_CORE_BIT3 3
`define CCR_CORE_BIT2 2
`define CCR_CORE_BIT1 1
`define CCR_CORE_LSB 0

// ==================================================================
// Core voltage mapping, millivolts
`define CCR_CORE_BASE_MV 11'd800
`define CCR_CORE_STEP_MV 11'd25
`define CCR_CORE_TOP_MV 11'd1600
`define CCR_CORE_TOP_CODE 5'h1f

// ==================================================================
// Ramp timing
`define CCR_CLOCK_PERIOD_NS 10
`define CCR_RAMP_STEP_UV 25000
`define CCR_RAMP_BASE_RATE_UV_PER_US 150
`define CCR_RAMP_STEP_NS (`CCR_RAMP_STEP_UV * 1000 / `CCR_RAMP_BASE_RATE_UV_PER_US)
`define CCR_RAMP_STEP_CYCLES (`CCR_RAMP_STEP_NS / `CCR_CLOCK_PERIOD_NS)
`define CCR_RAMP_IMMEDIATE 3'h7

`endif

// File: design/converter_control_pkg.sv
// Types shared by the converter control bank and its ramp engine.
// Assumes the params header supplies all numeric constants.
package converter_control_pkg;
    // Five-bit core voltage code
    typedef logic [4:0] core_code_t;
    // Three-bit ramp rate code
    typedef logic [2:0] ramp_code_t;
    // Ramp engine states
    typedef enum logic [0:0] {
        RAMP_IDLE,
        RAMP_STEP
    } ramp_state_t;
endpackage

// File: design/ramp_if.sv
// Carrier between the register bank and the core ramp engine.
// Assumes one clock domain; no clocking block.
`timescale 1ns/1ps
interface ramp_if;
    logic start; // Start bit level
    logic jump; // Reload event, code jumps at once
    converter_control_pkg::core_code_t jumpCode; // Value taken on jump
    converter_control_pkg::core_code_t target; // Register code
    converter_control_pkg::ramp_code_t slew; // Rate code
    converter_control_pkg::core_code_t code; // Internal voltage code
    logic done; // Target reached while started
    logic busy; // Stepping in progress
    modport ctrl (output start, jump, jumpCode, target, slew, input code, done, busy);
    modport engine (input start, jump, jumpCode, target, slew, output code, done, busy);
endinterface

// File: design/core_ramp_engine.sv
// Core rail ramp engine: walks the internal code one step at a time, except at the immediate rate code 7 and on reload jumps.
// Assumes target and rate come straight from the register bank.
`timescale 1ns/1ps
`include "converter_control_params.svh"
module core_ramp_engine #(
    parameter int STEP_CYCLES = `CCR_RAMP_STEP_CYCLES,
    parameter int CNT_W = $clog2(STEP_CYCLES + 1)
) (
    input wire logic clock,
    input wire logic rst,
    ramp_if.engine rampBus
);
    // ==================================================================
    // State
    converter_control_pkg::ramp_state_t state_q; // Engine state
    converter_control_pkg::core_code_t code_q; // Internal voltage code
    logic [CNT_W-1:0] count_q; // Cycles left in this step
    logic [CNT_W-1:0] interval; // Step length for the chosen rate

    localparam logic [CNT_W-1:0] SLOWEST = CNT_W'(STEP_CYCLES);

    // Each rate code doubles the speed, so halve the step length
    assign interval = SLOWEST >> rampBus.slew;

    // Done looks at the code, not the real output level
    assign rampBus.done = rampBus.start && (code_q == rampBus.target) && !rampBus.jump;
    assign rampBus.busy = (state_q == converter_control_pkg::RAMP_STEP);
    assign rampBus.code = code_q;

    // ==================================================================
    // Stepping
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= converter_control_pkg::RAMP_IDLE;
            code_q <= `CCR_CORE_RST_PIN_LOW;
            count_q <= '0;
        end else if (rampBus.jump) begin
            // Reload events jump straight to the reloaded register code
            state_q <= converter_control_pkg::RAMP_IDLE;
            code_q <= rampBus.jumpCode;
        end else begin
            case (state_q)
                converter_control_pkg::RAMP_IDLE: begin
                    if (rampBus.start && (code_q != rampBus.target)) begin
                        if (rampBus.slew == `CCR_RAMP_IMMEDIATE) begin
                            code_q <= rampBus.target;
                        end else begin
                            state_q <= converter_control_pkg::RAMP_STEP;
                            count_q <= interval - 1'b1;
                        end
                    end
                end
                converter_control_pkg::RAMP_STEP: begin
                    if (!rampBus.start || (code_q == rampBus.target)) begin
                        state_q <= converter_control_pkg::RAMP_IDLE;
                    end else if (count_q == '0) begin
                        // One code step per interval, up or down
                        if (code_q < rampBus.target) begin
                            code_q <= code_q + 5'h01;
                        end else begin
                            code_q <= code_q - 5'h01;
                        end
                        count_q <= interval - 1'b1;
                    end else begin
                        count_q <= count_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= converter_control_pkg::RAMP_IDLE;
                end
            endcase
        end
    end
endmodule

// File: design/converter_control_regs.sv
// Converter control register bank: supply enables, converter mode and
// phase, core voltage change control, core code and ramp rate.
// Assumes a serial front end delivers decoded byte reads and writes,
// and all pin inputs are synchronous to clock.
`timescale 1ns/1ps
`include "converter_control_params.svh"

module converter_control_regs #(
    parameter int STEP_CYCLES = `CCR_RAMP_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    // Decoded register access from the serial front end
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Device level pins and events
    input wire logic undervoltageLockout,
    input wire logic linearRegEnablePin,
    input wire logic firstConverterEnablePin,
    input wire logic secondConverterEnablePin,
    input wire logic coreConverterEnablePin,
    input wire logic warmResetPin_n,
    input wire logic powerOnResetOut,
    input wire logic backupRailLow,
    input wire logic coreDefaultPin,
    // Supply control
    output logic firstLinearOn,
    output logic secondLinearOn,
    output logic [2:0] converterOn,
    output logic [2:0] forcedFixedFreq,
    output logic lowRipple,
    output logic [1:0] firstPhaseDelay,
    output logic [1:0] secondPhaseDelay,
    output logic [1:0] corePhaseDelay,
    output logic [2:0] dischargeActive,
    // Core rail
    output logic coreFromRegister,
    output logic [4:0] coreRampCode,
    output logic [10:0] coreMillivolts,
    output logic coreRampBusy
);
    // ==================================================================
    // Elaboration checks
    // Six halvings must still leave a step of at least two cycles
    if (STEP_CYCLES < 128) begin : g_bad_step
        $error("STEP_CYCLES too small for the fastest ramp rate");
    end

    // ==================================================================
    // Declarations
    // Converter vectors: [2] second, [1] first, [0] core
    logic [1:0] linearEn_q; // [1] second, [0] first linear enables
    logic [1:0] linearEn_d;
    logic [2:0] convEn_q; // Converter enable bits
    logic [2:0] convEn_d;
    logic [2:0] convPin; // Converter enable pins, same order
    logic [7:0] modePhase_q; // Mode and phase register
    logic [7:0] modePhase_d;
    logic start_q; // Start bit
    logic start_d;
    logic coreAdj_q; // Core-adjust bit
    logic coreAdj_d;
    logic [2:0] discharge_q; // Discharge bits
    logic [2:0] discharge_d;
    converter_control_pkg::core_code_t coreCode_q; // Core code register
    converter_control_pkg::core_code_t coreCode_d;
    converter_control_pkg::ramp_code_t rampRate_q; // Ramp rate register
    converter_control_pkg::ramp_code_t rampRate_d;
    logic initLoad_q; // First cycle after reset release
    logic wideReload; // Reload set for core bits 3:1 and core-adjust
    logic firstReload; // Reload set for core bits 4 and 0
    logic [7:0] readMux; // Selected read value
    logic [10:0] millivolts_d; // Next core voltage figure
    logic [7:0] supplyEnableView; // Read view of enable register
    converter_control_pkg::core_code_t coreDefault; // Pin-chosen default
    ramp_if rampBus();

    assign convPin = {secondConverterEnablePin, firstConverterEnablePin,
                      coreConverterEnablePin};

    // ==================================================================
    // Reset event decoding
    // Default pin is a strap, so it is sampled after reset release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            initLoad_q <= 1'b1;
        end else begin
            initLoad_q <= 1'b0;
        end
    end

    // Both sets share lockout, warm reset, power-on reset, backup rail
    assign wideReload = undervoltageLockout || initLoad_q || !warmResetPin_n
                        || powerOnResetOut || backupRailLow
                        || (!firstConverterEnablePin && !coreConverterEnablePin);
    assign firstReload = undervoltageLockout || initLoad_q || !warmResetPin_n
                         || powerOnResetOut || backupRailLow
                         || !firstConverterEnablePin;

    // Default 14h with pin low, 1Eh with pin high
    assign coreDefault = coreDefaultPin ? `CCR_CORE_RST_PIN_HIGH
                                        : `CCR_CORE_RST_PIN_LOW;

    // ==================================================================
    // Supply enable register
    // Lockout and pin resets outrank a host write in the same cycle
    always_comb begin
        linearEn_d = linearEn_q;
        if (undervoltageLockout) begin
            linearEn_d = 2'h3;
        end else if (!linearRegEnablePin) begin
            linearEn_d = 2'h3;
        end else if (regWrite && (regAddr == `CCR_ADDR_SUPPLY_ENABLE)) begin
            linearEn_d = {regWrData[`CCR_SE_SECOND_LIN],
                          regWrData[`CCR_SE_FIRST_LIN]};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            linearEn_q <= 2'h3;
        end else begin
            linearEn_q <= linearEn_d;
        end
    end

    // Converter enable bits reload when their own pin is low
    for (genvar i = 0; i < 3; i++) begin : g_conv_en
        localparam int POS = (i == 2) ? `CCR_SE_SECOND_CONV :
                             (i == 1) ? `CCR_SE_FIRST_CONV : `CCR_SE_CORE_CONV;
        always_comb begin
            convEn_d[i] = convEn_q[i];
            if (undervoltageLockout || !convPin[i]) begin
                convEn_d[i] = 1'b1;
            end else if (regWrite && (regAddr == `CCR_ADDR_SUPPLY_ENABLE)) begin
                convEn_d[i] = regWrData[POS];
            end
        end
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                convEn_q[i] <= 1'b1;
            end else begin
                convEn_q[i] <= convEn_d[i];
            end
        end
        // Disabled converter with its bit set drains its output
        assign dischargeActive[i] = discharge_q[i] && !converterOn[i];
    end

    // Unimplemented bits of this register read as their default ones
    always_comb begin
        supplyEnableView = `CCR_SUPPLY_ENABLE_RST;
        supplyEnableView[`CCR_SE_SECOND_LIN] = linearEn_q[1];
        supplyEnableView[`CCR_SE_FIRST_LIN] = linearEn_q[0];
        supplyEnableView[`CCR_SE_SECOND_CONV] = convEn_q[2];
        supplyEnableView[`CCR_SE_FIRST_CONV] = convEn_q[1];
        supplyEnableView[`CCR_SE_CORE_CONV] = convEn_q[0];
    end

    // Bit and pin must both be high
    assign secondLinearOn = linearEn_q[1] && linearRegEnablePin;
    assign firstLinearOn = linearEn_q[0] && linearRegEnablePin;
    assign converterOn = convEn_q & convPin;

    // ==================================================================
    // Converter mode and phase register
    always_comb begin
        modePhase_d = modePhase_q;
        if (undervoltageLockout) begin
            modePhase_d = `CCR_MODE_PHASE_RST;
        end else if (regWrite && (regAddr == `CCR_ADDR_MODE_PHASE)) begin
            modePhase_d = regWrData;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modePhase_q <= `CCR_MODE_PHASE_RST;
        end else begin
            modePhase_q <= modePhase_d;
        end
    end

    // Codes 0..3 give zero to three quarters of a switching cycle
    assign secondPhaseDelay = modePhase_q[`CCR_MP_SECOND_PHASE +: 2];
    assign corePhaseDelay = modePhase_q[`CCR_MP_CORE_PHASE +: 2];
    // Reference converter, no field can shift it
    assign firstPhaseDelay = 2'h0;
    assign lowRipple = modePhase_q[`CCR_MP_LOW_RIPPLE];
    assign forcedFixedFreq = modePhase_q[2:0];

    // ==================================================================
    // Voltage change control register
    always_comb begin
        start_d = start_q;
        if (undervoltageLockout) begin
            start_d = 1'b0;
        end else if (regWrite && (regAddr == `CCR_ADDR_VOLT_CHANGE)
                     && regWrData[`CCR_VC_START]) begin
            // A host set wins over a finishing ramp
            start_d = 1'b1;
        end else if (rampBus.done) begin
            start_d = 1'b0;
        end else if (regWrite && (regAddr == `CCR_ADDR_VOLT_CHANGE)) begin
            start_d = 1'b0;
        end
    end

    always_comb begin
        coreAdj_d = coreAdj_q;
        if (wideReload) begin
            coreAdj_d = 1'b1;
        end else if (regWrite && (regAddr == `CCR_ADDR_VOLT_CHANGE)) begin
            coreAdj_d = regWrData[`CCR_VC_CORE_ADJ];
        end
    end

    always_comb begin
        discharge_d = discharge_q;
        if (undervoltageLockout) begin
            discharge_d = 3'h0;
        end else if (regWrite && (regAddr == `CCR_ADDR_VOLT_CHANGE)) begin
            discharge_d = regWrData[2:0];
        end
    end

    // Default 40h: start clear, core-adjust set, no discharge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_q <= 1'(`CCR_VOLT_CHANGE_RST >> `CCR_VC_START);
            coreAdj_q <= 1'b1;
            discharge_q <= 3'h0;
        end else begin
            start_q <= start_d;
            coreAdj_q <= coreAdj_d;
            discharge_q <= discharge_d;
        end
    end

    // Core-adjust clear hands the rail to the register code
    assign coreFromRegister = !coreAdj_q;

    // ==================================================================
    // Core voltage code register
    always_comb begin
        coreCode_d = coreCode_q;
        if (regWrite && (regAddr == `CCR_ADDR_CORE_CODE)) begin
            coreCode_d = regWrData[4:0];
        end
        if (wideReload) begin
            coreCode_d[`CCR_CORE_BIT3] = coreDefault[`CCR_CORE_BIT3];
            coreCode_d[`CCR_CORE_BIT2] = coreDefault[`CCR_CORE_BIT2];
            coreCode_d[`CCR_CORE_BIT1] = coreDefault[`CCR_CORE_BIT1];
        end
        if (firstReload) begin
            coreCode_d[`CCR_CORE_MSB] = coreDefault[`CCR_CORE_MSB];
            coreCode_d[`CCR_CORE_LSB] = coreDefault[`CCR_CORE_LSB];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            coreCode_q <= `CCR_CORE_RST_PIN_LOW;
        end else begin
            coreCode_q <= coreCode_d;
        end
    end

    // ==================================================================
    // Ramp rate register
    always_comb begin
        rampRate_d = rampRate_q;
        if (undervoltageLockout) begin
            rampRate_d = `CCR_RAMP_RATE_RST;
        end else if (regWrite && (regAddr == `CCR_ADDR_RAMP_RATE)) begin
            rampRate_d = regWrData[2:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rampRate_q <= `CCR_RAMP_RATE_RST;
        end else begin
            rampRate_q <= rampRate_d;
        end
    end

    // ==================================================================
    // Ramp engine
    // Any reload of the code drags the internal code with it, so a
    // pin reset never leaves a ramp running toward a stale value
    assign rampBus.start = start_q;
    assign rampBus.jump = wideReload || firstReload;
    assign rampBus.jumpCode = coreCode_d;
    assign rampBus.target = coreCode_q;
    assign rampBus.slew = rampRate_q;

    core_ramp_engine #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_engine (
        .clock(clock),
        .rst(rst),
        .rampBus(rampBus.engine)
    );

    assign coreRampCode = rampBus.code;
    assign coreRampBusy = rampBus.busy;

    // ==================================================================
    // Core voltage figure
    // Linear steps, but the top code jumps a double step
    always_comb begin
        if (rampBus.code == `CCR_CORE_TOP_CODE) begin
            millivolts_d = `CCR_CORE_TOP_MV;
        end else begin
            millivolts_d = `CCR_CORE_BASE_MV
                           + 11'(`CCR_CORE_STEP_MV * {6'h00, rampBus.code});
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            coreMillivolts <= `CCR_CORE_BASE_MV;
        end else begin
            coreMillivolts <= millivolts_d;
        end
    end

    // ==================================================================
    // Read path
    // Addresses outside this bank answer zero; the front end owns them
    always_comb begin
        if (regAddr == `CCR_ADDR_SUPPLY_ENABLE) begin
            readMux = supplyEnableView;
        end else if (regAddr == `CCR_ADDR_MODE_PHASE) begin
            readMux = modePhase_q;
        end else if (regAddr == `CCR_ADDR_VOLT_CHANGE) begin
            // Bits 5:3 unused, read zero
            readMux = {start_q, coreAdj_q, 3'h0, discharge_q};
        end else if (regAddr == `CCR_ADDR_CORE_CODE) begin
            readMux = {3'h0, coreCode_q};
        end else if (regAddr == `CCR_ADDR_RAMP_RATE) begin
            readMux = {5'h00, rampRate_q};
        end else begin
            readMux = `CCR_READ_NONE;
        end
    end

    // Read data held until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdData <= `CCR_READ_NONE;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                regRdData <= readMux;
            end
        end
    end
endmodule

// File: tb/converter_control_chk.sv
// Port checker for the converter control bank.
// Assumes a bind onto converter_control_regs; one clock domain.
`timescale 1ns/1ps
module converter_control_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic undervoltageLockout,
    input wire logic linearRegEnablePin,
    input wire logic firstLinearOn,
    input wire logic secondLinearOn,
    input wire logic [2:0] converterOn,
    input wire logic [2:0] forcedFixedFreq,
    input wire logic lowRipple,
    input wire logic [1:0] firstPhaseDelay,
    input wire logic [2:0] dischargeActive,
    input wire logic [4:0] coreRampCode,
    input wire logic [10:0] coreMillivolts
);
    // ====
    // Properties, all on the one clock
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_lin_pin_gate: assert property (!linearRegEnablePin |-> !firstLinearOn && !secondLinearOn)
        else $error("linear on while pin low");
    // Bits were forced while the pin was low, so both come back on
    a_lin_rearm: assert property ($rose(linearRegEnablePin) |-> firstLinearOn && secondLinearOn)
        else $error("linear not rearmed");
    a_first_phase: assert property (firstPhaseDelay == 2'h0)
        else $error("first phase not zero");
    a_mode_write: assert property (regWrite && regAddr == 8'h04 && !undervoltageLockout
        |=> {lowRipple, forcedFixedFreq} == $past(regWrData[3:0])) else $error("mode write lost");
    a_disch_off: assert property ((dischargeActive & converterOn) == 3'h0)
        else $error("discharge while on");
    // Millivolt output lags the code by one register stage
    a_mv_track: assert property (1'h1 |=> coreMillivolts == ($past(coreRampCode) == 5'h1f ?
        11'd1600 : 11'd800 + 11'd25 * $past(coreRampCode))) else $error("mv mismatch");
    a_rd_pulse: assert property (1'h1 |=> regRdValid == $past(regRead))
        else $error("read valid timing");
    a_rd_unmapped: assert property (regRead && regAddr > 8'h07 |=> regRdData == 8'h00)
        else $error("unmapped read nonzero");
    a_core_upper: assert property (regRead && regAddr == 8'h06 |=> regRdData[7:5] == 3'h0)
        else $error("core upper bits set");
    cover property (regRead && regAddr == 8'h05);
    cover property ($rose(linearRegEnablePin));
    cover property (undervoltageLockout);
endmodule

// File: tb/host_master_model.sv
// Host model: single-byte writes and reads on the decoded port.
// Assumes requests are sampled on the rising clock edge.
`timescale 1ns/1ps
module host_master_model (
    input wire logic clock,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData
);
    // Idle; writes release address and data inverted, reads release only the address inverted
    initial begin
        regWrite = 1'h0;
        regRead = 1'h0;
        regAddr = 8'hff;
        regWrData = 8'h00;
    end
    // Write held across one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'h1;
        @(negedge clock);
        regWrite = 1'h0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    // Read; data is taken half a cycle after the request edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRead = 1'h1;
        @(negedge clock);
        regRead = 1'h0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule

// File: tb/test_converter_control_regs.sv
// Self-checking bench for converter_control_regs.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module test_converter_control_regs;
    // ====
    // Stimulus and results
    logic clock = 1'h0, rst = 1'h1, undervoltage_lockout = 1'h0, linPin = 1'h1, defPin = 1'h0, warmN = 1'h1;
    logic regWrite, regRead, regRdValid, firstLinearOn, secondLinearOn, lowRipple;
    logic coreFromRegister, coreRampBusy, firstPin = 1'h1;
    logic [7:0] regAddr, regWrData, regRdData, v;
    logic [2:0] converterOn, forcedFixedFreq, dischargeActive;
    logic [1:0] firstPhaseDelay, secondPhaseDelay, corePhaseDelay;
    logic [4:0] coreRampCode;
    logic [10:0] coreMillivolts;
    int n_errors = 0, total_checks = 0;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    row_t rows [11] = '{'{1'h0, 8'h03, 8'h00, 8'hff},
        '{1'h0, 8'h04, 8'h00, 8'hb1}, '{1'h0, 8'h05, 8'h00, 8'h40},
        '{1'h0, 8'h06, 8'h00, 8'h14}, '{1'h0, 8'h07, 8'h00, 8'h06},
        '{1'h1, 8'h04, 8'h5a, 8'h5a}, '{1'h1, 8'h05, 8'h3f, 8'h07},
        '{1'h1, 8'h06, 8'hff, 8'h1f}, '{1'h1, 8'h07, 8'hff, 8'h07},
        '{1'h1, 8'h0a, 8'h55, 8'h00}, '{1'h1, 8'h03, 8'h00, 8'hc1}};
    always #5 clock = ~clock;
    converter_control_regs #(.STEP_CYCLES(128)) converter_control_regs_i (.clock(clock),
        .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .undervoltageLockout(undervoltage_lockout), .linearRegEnablePin(linPin),
        .firstConverterEnablePin(firstPin), .secondConverterEnablePin(1'h1),
        .coreConverterEnablePin(1'h1), .warmResetPin_n(warmN), .powerOnResetOut(1'h0),
        .backupRailLow(1'h0), .coreDefaultPin(defPin), .firstLinearOn(firstLinearOn),
        .secondLinearOn(secondLinearOn), .converterOn(converterOn),
        .forcedFixedFreq(forcedFixedFreq), .lowRipple(lowRipple),
        .firstPhaseDelay(firstPhaseDelay), .secondPhaseDelay(secondPhaseDelay),
        .corePhaseDelay(corePhaseDelay), .dischargeActive(dischargeActive),
        .coreFromRegister(coreFromRegister), .coreRampCode(coreRampCode),
        .coreMillivolts(coreMillivolts), .coreRampBusy(coreRampBusy));
    host_master_model host_master_model_i (.clock(clock), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
    // Case-equality compare, counted
    task automatic chk(input string s, input logic [10:0] g, input logic [10:0] e);
        total_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Table rows: optional write, then readback
    task automatic run(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            if (rows[i].w) host_master_model_i.wr(rows[i].a, rows[i].d);
            host_master_model_i.rd(rows[i].a, v);
            chk("reg", v, rows[i].e);
        end
    endtask
    // Start a ramp and poll the start bit under a bound
    task automatic ramp(input logic [4:0] e);
        int n = 0;
        host_master_model_i.wr(8'h05, 8'h80);
        do begin
            host_master_model_i.rd(8'h05, v);
            n++;
        end while (v[7] !== 1'h0 && n < 300);
        chk("start", v[7], 1'h0);
        chk("code", coreRampCode, e);
        chk("mv", coreMillivolts, e == 5'h1f ? 11'd1600 : 11'd800 + 11'd25 * e);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'h0;
        run(0, 10);
        chk("mode", {secondPhaseDelay, corePhaseDelay, lowRipple, forcedFixedFreq}, 8'h5a);
        chk("src", coreFromRegister, 1'h1);
        chk("lin", {firstLinearOn, secondLinearOn, dischargeActive}, 5'h07);
        linPin = 1'h0;
        repeat (2) @(negedge clock);
        linPin = 1'h1;
        @(negedge clock);
        chk("rearm", {firstLinearOn, secondLinearOn}, 2'h3);
        ramp(5'h1f);
        host_master_model_i.wr(8'h07, 8'h06);
        host_master_model_i.wr(8'h06, 8'h1d);
        ramp(5'h1d);
        firstPin = 1'h0;
        @(negedge clock) firstPin = 1'h1;
        chk("first", coreRampCode, 5'h1c);
        $display("table, pins and ramps done");
        undervoltage_lockout = 1'h1;
        @(negedge clock);
        undervoltage_lockout = 1'h0;
        run(0, 4);
        chk("jump", coreRampCode, 5'h14);
        host_master_model_i.wr(8'h05, 8'h00);
        defPin = 1'h1;
        warmN = 1'h0;
        @(negedge clock);
        warmN = 1'h1;
        host_master_model_i.rd(8'h06, v);
        chk("warm", v, 8'h1e);
        host_master_model_i.rd(8'h05, v);
        chk("adj", v, 8'h40);
        $display("lockout and warm reset done");
        final_report();
    end
endmodule
bind converter_control_regs converter_control_chk converter_control_chk_i (.*);
